// >>> dv/sqwr_sample_src.sv
// sample source model, one sample set per sample-rate tick
`timescale 1ns/100ps
module sqwr_sample_src (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_push,
	output logic             o_sample_valid,
	output logic [47:0]      o_sample_data
);
	logic [4:0] seq;
	// numbered sets in order; data toggles while idle so it is never stale
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			seq            <= 5'h0;
			o_sample_valid <= 1'b0;
			o_sample_data  <= 48'h0000_0000_0000;
		end else if (i_push) begin
			seq            <= seq + 5'h1;
			o_sample_valid <= 1'b1;
			o_sample_data  <= {seq, 3'h5, seq, 3'h4, seq, 3'h3, seq, 3'h2, seq, 3'h1, seq, 3'h0};
		end else begin
			o_sample_valid <= 1'b0;
			o_sample_data  <= ~o_sample_data;
		end
	end
endmodule // sqwr_sample_src

// >>> dv/sqwr_top_asserts.sv
// concurrent checks on the register bus of the sample queue readout
`timescale 1ns/100ps
module sqwr_top_asserts
	import sqwr_pkg::*;
#(
	parameter int DEPTH     = 32,
	parameter int SET_BYTES = 6
) (
	input wire logic        i_ref_clk,
	input wire logic        i_rst,
	input wire logic        i_awvalid,
	input wire logic        o_awready,
	input wire logic        i_wvalid,
	input wire logic        o_wready,
	input wire logic        o_bvalid,
	input wire logic        i_bready,
	input wire logic [1:0]  o_bresp,
	input wire logic        i_arvalid,
	input wire logic        o_arready,
	input wire logic [7:0]  i_araddr,
	input wire logic        o_rvalid,
	input wire logic        i_rready,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0]  o_rresp
);
	// ------------------------------------------------------------
	// handshake steps
	// ------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	sequence ar_take; i_arvalid && o_arready; endsequence
	sequence wr_take; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
	sequence out_addr; i_araddr >= 8'hA0 && i_araddr <= 8'hB8; endsequence

	a_ar_answer: assert property (ar_take |=> o_rvalid)
		else $error("read answer missing");
	a_read_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
		else $error("read answer dropped early");
	a_ar_refused: assert property (o_rvalid |-> !o_arready)
		else $error("read taken while answer pending");
	a_out_byte: assert property (ar_take ##0 out_addr |=> o_rdata[31:8] == 24'h00_0000)
		else $error("output register wider than a byte");
	a_unmapped_read: assert property (ar_take ##0 i_araddr == 8'hFC |=> o_rresp == SQWR_RESP_SLVERR && o_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_write_answer: assert property (wr_take |-> ##[1:2] o_bvalid)
		else $error("write answer missing");
	a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write answer dropped early");
	a_ready_pulse: assert property (o_arready |=> !o_arready)
		else $error("read ready held");
endmodule // sqwr_top_asserts

bind sqwr_top sqwr_top_asserts #(.DEPTH(DEPTH), .SET_BYTES(SET_BYTES)) u_asserts (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_awvalid(i_awvalid), .o_awready(o_awready),
	.i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
	.o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
	.o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp));

// >>> dv/sqwr_top_tb.sv
// self-checking bench for the sample queue readout
`timescale 1ns/100ps
module sqwr_top_tb;
	import sqwr_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, push = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  wstrb = 4'hF;
	logic        sv, awready, wready, bvalid, arready, rvalid, irq, pin;
	logic [47:0] sd;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [4:0]  seq = 5'h0;
	int          bad_count = 0, checks = 0;

	// clock and parts
	always #5 clk = ~clk;
	sqwr_sample_src src (.i_ref_clk(clk), .i_rst(rst), .i_push(push), .o_sample_valid(sv), .o_sample_data(sd));
	sqwr_top dut (.i_ref_clk(clk), .i_rst(rst), .i_sample_valid(sv), .i_sample_data(sd),
		.i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
		.i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
		.i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
		.o_rdata(rdata), .o_rresp(rresp), .o_irq(irq), .o_irq_pin_one(pin));

	// ------------------------------------------------------------
	// bus tasks and compare
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// write: address and data together, response stalled one cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ga, gw;
		ga = 1'b0;
		gw = 1'b0;
		{awvalid, wvalid, awaddr, wdata} <= {2'h3, a, d};
		while (!(ga && gw)) begin
			@(posedge clk);
			if (awready === 1'b1) begin
				ga = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1) begin
				gw = 1'b1;
				wvalid <= 1'b0;
			end
		end
		repeat (2) @(posedge clk);
		bready <= 1'b1;
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	// read: answer stalled one cycle before rready
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		{arvalid, araddr} <= {1'b1, a};
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		@(posedge clk);
		rready <= 1'b1;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, e);
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	// one set of six bytes, by output registers or stream port
	task automatic rdset(input logic [4:0] n, input logic strm);
		for (int k = 0; k < 6; k++) begin
			rd(strm ? 8'hB8 : 8'hA0 + 8'(4 * k), {24'h00_0000, n, 3'(k)}, SQWR_RESP_OKAY);
		end
	endtask
	task automatic load(input int cnt);
		push <= 1'b1;
		repeat (cnt) @(posedge clk);
		push <= 1'b0;
		repeat (4) @(posedge clk);
		seq = seq + cnt[4:0];
	endtask
	task automatic pins(input logic [1:0] e);
		repeat (2) @(posedge clk);
		chk({30'h0, irq, pin}, {30'h0, e});
	endtask
	task automatic results();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(SQWR_ADDR_SOURCE_STAT, 32'h0000_0000, SQWR_RESP_OKAY);
		rd(SQWR_ADDR_QUEUE_CTRL, 32'h0000_0000, SQWR_RESP_OKAY);
		wr(SQWR_ADDR_QUEUE_CTRL, 32'h0000_1F03, SQWR_RESP_OKAY);
		rd(SQWR_ADDR_QUEUE_CTRL, 32'h0000_1F03, SQWR_RESP_OKAY);
		wr(SQWR_ADDR_QUEUE_CTRL, 32'h0000_0303, SQWR_RESP_OKAY);
		wr(SQWR_ADDR_IRQ1_ROUTE, 32'h0000_0001, SQWR_RESP_OKAY);
		wr(SQWR_ADDR_IRQ_MASK, 32'h0000_0007, SQWR_RESP_OKAY);
		load(4);
		rd(SQWR_ADDR_SOURCE_STAT, 32'h0000_0084, SQWR_RESP_OKAY);
		pins(2'h3);
		$display("test fill done");
		rdset(5'h0, 1'b0);
		rd(SQWR_ADDR_SOURCE_STAT, 32'h0000_0083, SQWR_RESP_OKAY);
		pins(2'h3);
		rdset(5'h1, 1'b1);
		rd(SQWR_ADDR_SOURCE_STAT, 32'h0000_0002, SQWR_RESP_OKAY);
		pins(2'h2);
		rdset(5'h2, 1'b1);
		rdset(5'h3, 1'b0);
		rd(SQWR_ADDR_SOURCE_STAT, 32'h0000_0000, SQWR_RESP_OKAY);
		rdset(5'h3, 1'b1);
		rd(SQWR_ADDR_SOURCE_STAT, 32'h0000_0020, SQWR_RESP_OKAY);
		$display("test drain done");
		rd(SQWR_ADDR_IRQ_STATUS, 32'h0000_0005, SQWR_RESP_OKAY);
		wr(SQWR_ADDR_IRQ_MASK, 32'h0000_0000, SQWR_RESP_OKAY);
		pins(2'h0);
		wr(SQWR_ADDR_IRQ_MASK, 32'h0000_0007, SQWR_RESP_OKAY);
		pins(2'h2);
		wr(SQWR_ADDR_IRQ_STATUS, 32'h0000_0007, SQWR_RESP_OKAY);
		rd(SQWR_ADDR_IRQ_STATUS, 32'h0000_0000, SQWR_RESP_OKAY);
		pins(2'h0);
		rd(8'hFC, 32'h0000_0000, SQWR_RESP_SLVERR);
		wr(8'hFC, 32'h0000_0001, SQWR_RESP_SLVERR);
		$display("test irq done");
		load(33);
		rd(SQWR_ADDR_SOURCE_STAT, 32'h0000_00C0, SQWR_RESP_OKAY);
		rdset(seq, 1'b0);
		rd(SQWR_ADDR_SOURCE_STAT, 32'h0000_009F, SQWR_RESP_OKAY);
		wr(SQWR_ADDR_QUEUE_CTRL, 32'h0000_0301, SQWR_RESP_OKAY);
		rd(SQWR_ADDR_SOURCE_STAT, 32'h0000_0000, SQWR_RESP_OKAY);
		$display("test full done");
		results();
	end

	// watchdog
	initial begin
		#100000;
		bad_count++;
		results();
	end
endmodule // sqwr_top_tb

// >>> logic/sqwr_pkg.sv
// constants for the sample queue watermark readout block
package sqwr_pkg;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] SQWR_ADDR_QUEUE_CTRL   = 8'h00;
	localparam logic [7:0] SQWR_ADDR_IRQ1_ROUTE   = 8'h04;
	localparam logic [7:0] SQWR_ADDR_SOURCE_STAT  = 8'h08;
	localparam logic [7:0] SQWR_ADDR_IRQ_STATUS   = 8'h0C;
	localparam logic [7:0] SQWR_ADDR_IRQ_MASK     = 8'h10;
	localparam logic [7:0] SQWR_ADDR_OUT_STREAM   = 8'hB8;

	// output register indices, byte address is four times the index
	localparam logic [7:0] SQWR_IDX_OUT_FIRST     = 8'h28;
	localparam logic [7:0] SQWR_IDX_OUT_LAST      = 8'h2D;
	localparam int         SQWR_SET_BYTES         = 6;
	localparam int         SQWR_DEPTH             = 32;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int SQWR_CTRL_EN_BIT     = 0;
	localparam int SQWR_CTRL_MODE_LSB   = 1;
	localparam int SQWR_CTRL_WM_LSB     = 8;
	localparam int SQWR_STAT_EMPTY_BIT  = 5;
	localparam int SQWR_STAT_OVRUN_BIT  = 6;
	localparam int SQWR_STAT_FLAG_BIT   = 7;
	localparam int SQWR_IRQ_FLAG_BIT    = 0;
	localparam int SQWR_IRQ_OVRUN_BIT   = 1;
	localparam int SQWR_IRQ_EMPTY_BIT   = 2;

	// ------------------------------------------------------------
	// reset values and bus answers
	// ------------------------------------------------------------
	localparam logic [12:0] SQWR_CTRL_RST     = 13'h0000;
	localparam logic [2:0]  SQWR_IRQ_RST      = 3'h0;
	localparam logic [1:0]  SQWR_MODE_BYPASS  = 2'h0;
	localparam logic [1:0]  SQWR_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  SQWR_RESP_SLVERR  = 2'h2;

endpackage

// >>> logic/sqwr_top.sv
// sample queue with watermark flag and auto-advancing readout over axi4-lite
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// Behaviour
// R1 - software sets a five-bit watermark level, any value 0 to 31.
// R2 - a five-bit status field always shows how many sets the queue holds; a full queue of 32 sets reads as 0.
// R3 - flag rises when count exceeds level, falls when count drops below it.
// R4 - count rises per incoming sample, falls per completed set read.
// R5 - with route enable set, the flag drives interrupt pin one.
// R6 - queue enabled and not bypass: output registers show oldest stored set.
// R7 - reading output registers moves data out, advances queue, shows next oldest set.
// R8 - each slot holds six bytes; the queue holds thirty-two slots.
// R9 - after draining, reads repeat the last delivered set until new data arrives.
// R10 - host may drain with any mix of single and multi-byte reads.
// R11 - multi-byte reads auto-increment address, wrapping last output register to first.
// R12 - host should drain all slots within one sample period, choosing rate to suit.
// R13 - empty shows only after one extra repeated read, which host discards.
// R14 - incoming samples fill the slots in order at the sample rate.
// R15 - count equal to level holds the flag; pin follows flag directly.
module sqwr_top #(
	parameter int DEPTH     = sqwr_pkg::SQWR_DEPTH,
	parameter int SET_BYTES = sqwr_pkg::SQWR_SET_BYTES
) (
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_rst,
	// incoming sample sets, one pulse per output_sample_rate tick
	input  wire logic                    i_sample_valid,
	input  wire logic [SET_BYTES*8-1:0]  i_sample_data,
	// axi4-lite slave
	input  wire logic                    i_awvalid,
	output logic                         o_awready,
	input  wire logic [7:0]              i_awaddr,
	input  wire logic                    i_wvalid,
	output logic                         o_wready,
	input  wire logic [31:0]             i_wdata,
	input  wire logic [3:0]              i_wstrb,
	output logic                         o_bvalid,
	input  wire logic                    i_bready,
	output logic [1:0]                   o_bresp,
	input  wire logic                    i_arvalid,
	output logic                         o_arready,
	input  wire logic [7:0]              i_araddr,
	output logic                         o_rvalid,
	input  wire logic                    i_rready,
	output logic [31:0]                  o_rdata,
	output logic [1:0]                   o_rresp,
	// interrupts
	output logic                         o_irq,
	output logic                         o_irq_pin_one
);
	import sqwr_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam int DW = SET_BYTES * 8;

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (DEPTH != (1 << AW) || DEPTH < 2 || DEPTH > 32) begin : g_bad_depth
		$error("DEPTH must be a power of two from 2 to 32");
	end
	if (SET_BYTES != 6) begin : g_bad_set
		$error("SET_BYTES must match the six output registers");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [DW-1:0]    mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [CW-1:0]    count;
	logic [DW-1:0]    last_set;
	logic             level_reached_flag;
	logic             empty_flag;
	logic             overrun_flag;
	logic [2:0]       stream_idx;
	logic [12:0]      queue_ctrl;
	logic             level_irq_route_enable;
	logic [2:0]       irq_status;
	logic [2:0]       irq_mask;
	logic             aw_hold;
	logic             w_hold;
	logic [7:0]       aw_addr;
	logic [31:0]      w_data;
	logic [3:0]       w_strb;

	// ------------------------------------------------------------
	// control decode
	// ------------------------------------------------------------
	wire       queue_en       = queue_ctrl[SQWR_CTRL_EN_BIT];
	wire [1:0] queue_mode     = queue_ctrl[SQWR_CTRL_MODE_LSB +: 2];
	wire [4:0] watermark_level = queue_ctrl[SQWR_CTRL_WM_LSB +: 5];             // [R1]
	wire       queue_active   = queue_en && (queue_mode != SQWR_MODE_BYPASS);
	wire       queue_full     = (count == CW'(DEPTH));
	wire       queue_nonempty = (count != '0);
	// full queue reads back as zero in the five-bit field, the compare still sees 32
	wire [4:0] stored_sample_count = 5'(count);                                 // [R2]

	// ------------------------------------------------------------
	// read address decode
	// ------------------------------------------------------------
	// output registers sit on word addresses, one byte per bus word
	wire       rd_take      = i_arvalid && o_arready;
	wire [7:0] ar_word      = {2'b00, i_araddr[7:2]};
	wire       rd_stream    = (i_araddr == SQWR_ADDR_OUT_STREAM);
	wire       rd_outreg    = (ar_word >= SQWR_IDX_OUT_FIRST) && (ar_word <= SQWR_IDX_OUT_LAST)
	                          && (i_araddr[1:0] == 2'b00);
	wire [2:0] reg_byte     = 3'(ar_word - SQWR_IDX_OUT_FIRST);
	wire [2:0] out_byte     = rd_stream ? stream_idx : reg_byte;                // [R11]
	wire       out_read     = rd_take && (rd_stream || rd_outreg);
	// the set is complete when its last byte leaves, in any access mix
	wire       set_done     = out_read && (out_byte == 3'(SET_BYTES - 1));      // [R10]

	// oldest set while data is held, else the last one delivered
	wire [DW-1:0] shown_set = (queue_active && queue_nonempty) ? mem[rd_ptr] : last_set; // [R6] [R9]
	wire [7:0]    shown_byte = shown_set[out_byte*8 +: 8];

	// ------------------------------------------------------------
	// queue movement
	// ------------------------------------------------------------
	// a full queue drops its oldest slot to take the new sample
	wire push      = queue_active && i_sample_valid;                             // [R14]
	wire pop       = queue_active && set_done && queue_nonempty;                 // [R7]
	wire drop_old  = push && !pop && queue_full;
	wire [CW-1:0] next_count = (push && !pop && !queue_full) ? CW'(count + 1'b1) :
	                           (pop && !push)                ? CW'(count - 1'b1) : count; // [R4]

	// watermark compare, hold when equal
	// compare at six bits so a small queue never truncates the level
	wire [5:0] cnt_ext   = 6'(next_count);
	wire [5:0] wm_ext    = {1'b0, watermark_level};
	wire next_flag = (cnt_ext > wm_ext) ? 1'b1 :
	                 (cnt_ext < wm_ext) ? 1'b0 : level_reached_flag;            // [R3] [R15]
	wire next_empty = queue_active && !push && set_done && !queue_nonempty;      // [R13]

	// interrupt events: flag and empty pulse for one cycle on the rising side of their cause, overrun on every dropped sample
	wire       ev_flag_rise = next_flag && !level_reached_flag;                 // [R3]
	wire       ev_overrun   = drop_old;
	wire       ev_empty     = next_empty && !empty_flag;                        // [R13]
	wire [2:0] irq_event    = {ev_empty, ev_overrun, ev_flag_rise};

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	wire        wr_do      = aw_hold && w_hold && !o_bvalid;
	wire [31:0] wr_mask    = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire [31:0] wr_bits    = w_data & wr_mask;
	wire        wr_ctrl    = wr_do && (aw_addr == SQWR_ADDR_QUEUE_CTRL);
	wire        wr_route   = wr_do && (aw_addr == SQWR_ADDR_IRQ1_ROUTE);
	wire        wr_istat   = wr_do && (aw_addr == SQWR_ADDR_IRQ_STATUS);
	wire        wr_imask   = wr_do && (aw_addr == SQWR_ADDR_IRQ_MASK);
	wire        wr_known   = wr_ctrl || wr_route || wr_istat || wr_imask;
	wire [12:0] next_ctrl  = (queue_ctrl & ~wr_mask[12:0]) | wr_bits[12:0];
	wire [2:0]  irq_clear  = wr_istat ? wr_bits[2:0] : 3'h0;
	// set wins over a clear in the same cycle
	wire [2:0]  next_istat = (irq_status & ~irq_clear) | irq_event;

	// ------------------------------------------------------------
	// read data mux
	// ------------------------------------------------------------
	wire [7:0] src_stat = {level_reached_flag, overrun_flag, empty_flag, stored_sample_count};
	// one select per readable register; an address hitting none answers with an error
	wire        sel_out   = rd_stream || rd_outreg;
	wire        sel_ctrl  = (i_araddr == SQWR_ADDR_QUEUE_CTRL);
	wire        sel_route = (i_araddr == SQWR_ADDR_IRQ1_ROUTE);
	wire        sel_stat  = (i_araddr == SQWR_ADDR_SOURCE_STAT);
	wire        sel_istat = (i_araddr == SQWR_ADDR_IRQ_STATUS);
	wire        sel_imask = (i_araddr == SQWR_ADDR_IRQ_MASK);
	wire        rd_known  = sel_out || sel_ctrl || sel_route || sel_stat || sel_istat || sel_imask;
	wire [31:0] rd_word =
		sel_out   ? {24'h00_0000, shown_byte} :
		sel_ctrl  ? {19'h0_0000, queue_ctrl} :
		sel_route ? {31'h0000_0000, level_irq_route_enable} :
		sel_stat  ? {24'h00_0000, src_stat} :
		sel_istat ? {29'h0000_0000, irq_status} :
		sel_imask ? {29'h0000_0000, irq_mask} : 32'h0000_0000;

	// ------------------------------------------------------------
	// queue storage, no reset needed on the data array
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_sample_data;                                         // [R8]
		end
	end

	// pointers, count and queue flags
	// leaving the queue modes empties it, so stale slots never resurface
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr             <= '0;
			rd_ptr             <= '0;
			count              <= '0;
			level_reached_flag <= 1'b0;
			empty_flag         <= 1'b0;
			overrun_flag       <= 1'b0;
		end else if (!queue_active) begin
			wr_ptr             <= '0;
			rd_ptr             <= '0;
			count              <= '0;
			level_reached_flag <= 1'b0;
			empty_flag         <= 1'b0;
			overrun_flag       <= 1'b0;
		end else begin
			wr_ptr             <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;             // [R14]
			rd_ptr             <= (pop || drop_old) ? AW'(rd_ptr + 1'b1) : rd_ptr; // [R7]
			count              <= next_count;                                     // [R4]
			level_reached_flag <= next_flag;                                      // [R3]
			empty_flag         <= push ? 1'b0 : (empty_flag || next_empty);       // [R13]
			overrun_flag       <= drop_old ? 1'b1 : (set_done ? 1'b0 : overrun_flag);
		end
	end

	// last delivered set, or live sample in bypass
	// keeps the repeat set for reads past the end of the queue
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			last_set <= '0;
		end else if (!queue_active && i_sample_valid) begin
			last_set <= i_sample_data;
		end else if (pop) begin
			last_set <= mem[rd_ptr];                                              // [R9]
		end
	end

	// stream pointer walks the six output registers and wraps
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			stream_idx <= 3'h0;
		end else if (rd_take && rd_stream) begin
			stream_idx <= (stream_idx == 3'(SET_BYTES - 1)) ? 3'h0 : 3'(stream_idx + 1'b1); // [R11]
		end
	end

	// ------------------------------------------------------------
	// control and interrupt registers
	// ------------------------------------------------------------
	// status bits set by events and cleared by writing ones
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			queue_ctrl             <= SQWR_CTRL_RST;
			level_irq_route_enable <= 1'b0;
			irq_mask               <= SQWR_IRQ_RST;
			irq_status             <= SQWR_IRQ_RST;
		end else begin
			queue_ctrl             <= wr_ctrl ? next_ctrl : queue_ctrl;          // [R1]
			level_irq_route_enable <= (wr_route && w_strb[0]) ? w_data[0] : level_irq_route_enable;
			irq_mask               <= (wr_imask && w_strb[0]) ? w_data[2:0] : irq_mask;
			irq_status             <= next_istat;
		end
	end

	// interrupt outputs from flops
	// both pins change one cycle after their cause
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_irq         <= 1'b0;
			o_irq_pin_one <= 1'b0;
		end else begin
			o_irq         <= |(next_istat & irq_mask);
			o_irq_pin_one <= level_irq_route_enable && next_flag && queue_active; // [R5] [R15]
		end
	end

	// ------------------------------------------------------------
	// axi4-lite write channels
	// ------------------------------------------------------------
	// ready pulses once per request and stays low while a write is pending
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_awready <= 1'b0;
			aw_hold   <= 1'b0;
			aw_addr   <= 8'h00;
		end else begin
			o_awready <= i_awvalid && !o_awready && !aw_hold && !o_bvalid;
			if (i_awvalid && o_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= i_awaddr;
			end else if (wr_do) begin
				aw_hold <= 1'b0;
			end
		end
	end

	// write data capture
	// data may arrive before or after its address
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_wready <= 1'b0;
			w_hold   <= 1'b0;
			w_data   <= 32'h0000_0000;
			w_strb   <= 4'h0;
		end else begin
			o_wready <= i_wvalid && !o_wready && !w_hold && !o_bvalid;
			if (i_wvalid && o_wready) begin
				w_hold <= 1'b1;
				w_data <= i_wdata;
				w_strb <= i_wstrb;
			end else if (wr_do) begin
				w_hold <= 1'b0;
			end
		end
	end

	// write response
	// unmapped writes are dropped but still answered, so the master never hangs
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_bvalid <= 1'b0;
			o_bresp  <= SQWR_RESP_OKAY;
		end else if (wr_do) begin
			o_bvalid <= 1'b1;
			o_bresp  <= wr_known ? SQWR_RESP_OKAY : SQWR_RESP_SLVERR;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read channels
	// ------------------------------------------------------------
	// side effects land on the handshake edge only, so a stalled rready cannot pop twice
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0000_0000;
			o_rresp   <= SQWR_RESP_OKAY;
		end else begin
			o_arready <= i_arvalid && !o_arready && !o_rvalid;
			if (rd_take) begin
				o_rvalid <= 1'b1;
				o_rdata  <= rd_word;                                              // [R7]
				o_rresp  <= rd_known ? SQWR_RESP_OKAY : SQWR_RESP_SLVERR;
			end else if (i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

endmodule // sqwr_top
